// [src/vpr_pkg.sv]
/*
  Shared constants of the voltage PWM amplitude regulator.
  Assumes a single core clock; register map on a 32-bit AHB-Lite slave.
*/
package vpr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SPEED = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // Control register field positions
  localparam int CTRL_FB_SEL = 0;
  localparam int CTRL_QUIET_EN = 1;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_GAIN_LSB = 4;
  localparam int CTRL_RESTART_LSB = 8;
  localparam int CTRL_BLANK_LSB = 16;
  // Status register field positions
  localparam int STAT_AMP_LSB = 0;
  localparam int STAT_QUIET_ACT = 8;
  localparam int STAT_STANDSTILL = 9;
  localparam int STAT_MEAS_FAIL = 10;
  localparam int STAT_ARMED = 11;
  // Reset values
  localparam logic RST_FB_SEL = 1'b1;
  localparam logic RST_QUIET_EN = 1'b0;
  localparam logic [1:0] RST_RATE = 2'h0;
  localparam logic [3:0] RST_GAIN = 4'h4;
  localparam logic [7:0] RST_RESTART = 8'hFF;
  localparam logic [1:0] RST_BLANK = 2'h1;
  localparam logic [19:0] RST_SPEED = 20'h00000;
  localparam logic [7:0] RST_AMP = 8'h00;
  // Last PWM count (period minus one clock cycle) for divider codes 00..11
  localparam logic [9:0] PERIOD_0 = 10'd1023;
  localparam logic [9:0] PERIOD_1 = 10'd682;
  localparam logic [9:0] PERIOD_2 = 10'd511;
  localparam logic [9:0] PERIOD_3 = 10'd409;
  // Comparator blanking in clock cycles for codes 00..11
  localparam logic [9:0] BLANK_0 = 10'd16;
  localparam logic [9:0] BLANK_1 = 10'd24;
  localparam logic [9:0] BLANK_2 = 10'd36;
  localparam logic [9:0] BLANK_3 = 10'd54;
  // Step interval saturation marks standstill
  localparam logic [19:0] TSTEP_MAX = 20'hFFFFF;
  // Step-rate window of 256 clocks
  localparam logic [7:0] WIN_LAST = 8'hFF;
  localparam logic [7:0] AMP_MAX = 8'hFF;
endpackage

// [src/vpr_pwm_if.sv]
/*
  Link between regulator and PWM period generator.
  Assumes both ends on the core clock.
*/
interface vpr_pwm_if;
  logic [1:0] rate_sel;
  logic [7:0] amplitude;
  logic period_end;
  logic on_phase;
  logic [9:0] on_cnt;
  modport gen (input rate_sel, input amplitude, output period_end, output on_phase,
    output on_cnt);
  modport reg_side (output rate_sel, output amplitude, input period_end, input on_phase,
    input on_cnt);
endinterface

// [src/vpr_pwm_gen.sv]
/*
  PWM period generator: divides the core clock by the selected period and
  drives a duty proportional to the amplitude. Assumes inputs on core_clk.
*/
module vpr_pwm_gen (
  input wire logic core_clk,
  input wire logic sys_rst,
  vpr_pwm_if.gen pif,
  output logic pwm_on
);
  typedef struct packed {
    logic [9:0] cnt;
    logic drive;
    logic [9:0] on_cnt;
    logic pend;
  } vpr_gen_s;

  vpr_gen_s st_ff;
  vpr_gen_s nxt_st;
  logic [9:0] last;
  logic [17:0] duty_lim;

  always_comb
  begin
    unique case (pif.rate_sel)
      2'h0: last = vpr_pkg::PERIOD_0;
      2'h1: last = vpr_pkg::PERIOD_1;
      2'h2: last = vpr_pkg::PERIOD_2;
      2'h3: last = vpr_pkg::PERIOD_3;
    endcase
    duty_lim = 18'(pif.amplitude) * 18'({8'h00, last} + 18'd1);
    nxt_st = st_ff;
    nxt_st.pend = (st_ff.cnt >= last);
    nxt_st.cnt = nxt_st.pend ? 10'h000 : st_ff.cnt + 10'd1;
    nxt_st.drive = ({nxt_st.cnt, 8'h00} < duty_lim);
    // Restart the count after the wrap so period end still sees the total
    if (st_ff.pend)
      nxt_st.on_cnt = {9'h000, st_ff.drive};
    else if (st_ff.drive)
      nxt_st.on_cnt = st_ff.on_cnt + 10'd1;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pwm_on = st_ff.drive;
  assign pif.period_end = st_ff.pend;
  assign pif.on_phase = st_ff.drive;
  assign pif.on_cnt = st_ff.on_cnt;
endmodule // vpr_pwm_gen

// [src/vpr_top.sv]
/*
  Voltage-mode PWM amplitude regulator with AHB-Lite register slave.
  Assumes step_pulse from same-clock logic and an asynchronous current
  comparator input from the coil sense path.
*/
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
// Overview of operation
// - Feedback select bit 1 gives current regulation, 0 feed-forward scaling.
// - Divider select codes give PWM at clock over 1024, 683, 512, 410.
// - Automatic mode samples current in on phase; steps amplitude by gain.
// - Feed-forward mode measures nothing; amplitude from settings and velocity only.
// - Quiet mode active only while velocity is at or below the upper speed threshold, or at any velocity when that threshold is zero.
// - Returning to quiet mode at falling velocity loads the restart amplitude.
// - Automatic regulation starts only while the motor stands still.
// - Collapsed amplitude stops regulation until the motor reaches standstill.
// - Measurement fails when on time is shorter than comparator blanking.
// - Feed-forward amplitude is restart plus gain times steps per 256 clocks.
module vpr_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic step_pulse,
  input wire logic coil_cur_above,
  output logic pwm_on,
  output logic quiet_active
);
  typedef struct packed {
    logic [1:0] sense_sync;
    logic fb_sel;
    logic quiet_en;
    logic [1:0] rate_sel;
    logic [3:0] gain;
    logic [7:0] restart;
    logic [1:0] blank_sel;
    logic [19:0] upper_speed;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [19:0] tstep_cnt;
    logic [19:0] tstep;
    logic [7:0] win_cnt;
    logic [8:0] win_steps;
    logic [8:0] step_rate;
    logic quiet_act;
    logic armed;
    logic tripped;
    logic meas_fail;
    logic [7:0] amp;
  } vpr_state_s;

  vpr_state_s st_ff;
  vpr_state_s nxt_st;
  vpr_pwm_if pif ();
  logic addr_ph;
  logic standstill;
  logic speed_ok;
  logic [9:0] blank;
  logic [12:0] ff_sum;
  logic [8:0] reg_sum;
  logic [31:0] ctrl_val;
  logic [31:0] stat_val;

  vpr_pwm_gen u_gen (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pif(pif),
    .pwm_on(pwm_on)
  );

  assign pif.rate_sel = st_ff.rate_sel;
  assign pif.amplitude = st_ff.quiet_act ? st_ff.amp : 8'h00;

  always_comb
  begin
    unique case (st_ff.blank_sel)
      2'h0: blank = vpr_pkg::BLANK_0;
      2'h1: blank = vpr_pkg::BLANK_1;
      2'h2: blank = vpr_pkg::BLANK_2;
      2'h3: blank = vpr_pkg::BLANK_3;
    endcase
    addr_ph = hsel && htrans[1] && hready;
    standstill = (st_ff.tstep_cnt == vpr_pkg::TSTEP_MAX);
    speed_ok = (st_ff.upper_speed == 20'h00000) || (st_ff.tstep >= st_ff.upper_speed);
    ctrl_val = '0;
    ctrl_val[vpr_pkg::CTRL_FB_SEL] = st_ff.fb_sel;
    ctrl_val[vpr_pkg::CTRL_QUIET_EN] = st_ff.quiet_en;
    ctrl_val[vpr_pkg::CTRL_RATE_LSB +: 2] = st_ff.rate_sel;
    ctrl_val[vpr_pkg::CTRL_GAIN_LSB +: 4] = st_ff.gain;
    ctrl_val[vpr_pkg::CTRL_RESTART_LSB +: 8] = st_ff.restart;
    ctrl_val[vpr_pkg::CTRL_BLANK_LSB +: 2] = st_ff.blank_sel;
    stat_val = '0;
    stat_val[vpr_pkg::STAT_AMP_LSB +: 8] = st_ff.amp;
    stat_val[vpr_pkg::STAT_QUIET_ACT] = st_ff.quiet_act;
    stat_val[vpr_pkg::STAT_STANDSTILL] = standstill;
    stat_val[vpr_pkg::STAT_MEAS_FAIL] = st_ff.meas_fail;
    stat_val[vpr_pkg::STAT_ARMED] = st_ff.armed;
    ff_sum = 13'(st_ff.restart) + 13'(st_ff.gain) * 13'(st_ff.step_rate);
    reg_sum = 9'(st_ff.amp) + 9'(st_ff.gain);

    nxt_st = st_ff;
    // Comparator synchroniser
    nxt_st.sense_sync = {st_ff.sense_sync[0], coil_cur_above};

    // Bus slave
    nxt_st.wr_pend = addr_ph && hwrite;
    if (addr_ph)
      nxt_st.wr_addr = haddr[7:0];
    if (addr_ph && !hwrite)
    begin
      unique case (haddr[7:0])
        vpr_pkg::OFS_CTRL: nxt_st.rdata = ctrl_val;
        vpr_pkg::OFS_SPEED: nxt_st.rdata = {12'h000, st_ff.upper_speed};
        vpr_pkg::OFS_STATUS: nxt_st.rdata = stat_val;
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
    if (st_ff.wr_pend && st_ff.wr_addr == vpr_pkg::OFS_CTRL)
    begin
      nxt_st.fb_sel = hwdata[vpr_pkg::CTRL_FB_SEL];
      nxt_st.quiet_en = hwdata[vpr_pkg::CTRL_QUIET_EN];
      nxt_st.rate_sel = hwdata[vpr_pkg::CTRL_RATE_LSB +: 2];
      nxt_st.gain = hwdata[vpr_pkg::CTRL_GAIN_LSB +: 4];
      nxt_st.restart = hwdata[vpr_pkg::CTRL_RESTART_LSB +: 8];
      nxt_st.blank_sel = hwdata[vpr_pkg::CTRL_BLANK_LSB +: 2];
    end
    if (st_ff.wr_pend && st_ff.wr_addr == vpr_pkg::OFS_SPEED)
      nxt_st.upper_speed = hwdata[19:0];

    // Step interval and step rate
    if (step_pulse)
    begin
      nxt_st.tstep = st_ff.tstep_cnt;
      nxt_st.tstep_cnt = 20'h00000;
    end
    else if (!standstill)
      nxt_st.tstep_cnt = st_ff.tstep_cnt + 20'd1;
    else
      nxt_st.tstep = vpr_pkg::TSTEP_MAX;
    nxt_st.win_cnt = st_ff.win_cnt + 8'd1;
    if (st_ff.win_cnt == vpr_pkg::WIN_LAST)
    begin
      nxt_st.step_rate = st_ff.win_steps + 9'(step_pulse);
      nxt_st.win_steps = 9'h000;
    end
    else
      nxt_st.win_steps = st_ff.win_steps + 9'(step_pulse);

    // Quiet mode gating by velocity
    nxt_st.quiet_act = st_ff.quiet_en && speed_ok;

    // Current trip seen after blanking in the on phase
    if (pif.period_end)
      nxt_st.tripped = 1'b0;
    else if (pif.on_phase && pif.on_cnt >= blank && st_ff.sense_sync[1])
      nxt_st.tripped = 1'b1;

    // Arming: only at standstill, dropped on collapse or leaving auto mode
    if (!st_ff.fb_sel || !st_ff.quiet_en)
      nxt_st.armed = 1'b0;
    else if (standstill)
      nxt_st.armed = 1'b1;
    else if (st_ff.amp == 8'h00)
      nxt_st.armed = 1'b0;

    // Amplitude update
    if (st_ff.quiet_en && speed_ok && !st_ff.quiet_act)
      nxt_st.amp = st_ff.restart;
    else if (!st_ff.fb_sel)
      nxt_st.amp = (ff_sum > 13'(vpr_pkg::AMP_MAX)) ? vpr_pkg::AMP_MAX : ff_sum[7:0];
    else if (st_ff.quiet_act && pif.period_end)
    begin
      nxt_st.meas_fail = (pif.on_cnt < blank);
      if (st_ff.armed && pif.on_cnt >= blank)
      begin
        if (st_ff.tripped)
          nxt_st.amp = (st_ff.amp < 8'(st_ff.gain)) ? 8'h00 : st_ff.amp - 8'(st_ff.gain);
        else
          nxt_st.amp = reg_sum[8] ? vpr_pkg::AMP_MAX : reg_sum[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
      st_ff.fb_sel <= vpr_pkg::RST_FB_SEL;
      st_ff.quiet_en <= vpr_pkg::RST_QUIET_EN;
      st_ff.rate_sel <= vpr_pkg::RST_RATE;
      st_ff.gain <= vpr_pkg::RST_GAIN;
      st_ff.restart <= vpr_pkg::RST_RESTART;
      st_ff.blank_sel <= vpr_pkg::RST_BLANK;
      st_ff.upper_speed <= vpr_pkg::RST_SPEED;
      st_ff.amp <= vpr_pkg::RST_AMP;
      // No step since reset counts as standstill
      st_ff.tstep_cnt <= vpr_pkg::TSTEP_MAX;
      st_ff.tstep <= vpr_pkg::TSTEP_MAX;
    end
    else
      st_ff <= nxt_st;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign quiet_active = st_ff.quiet_act;
endmodule // vpr_top

// [dv/vpr_asserts.sv]
/* Port checker for vpr_top.
   Assumes bind to vpr_top, zero wait state slave. */
module vpr_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic pwm_on,
  input wire logic quiet_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic wr_ff;
  logic [7:0] wa_ff;
  logic [17:0] ctl_ff;
  logic [19:0] spd_ff;
  wire logic rd = hsel && htrans[1] && hready && !hwrite;
  // Shadow of written control and speed
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h00;
      ctl_ff <= 18'h1FF41;
      spd_ff <= 20'h00000;
    end
    else
    begin
      wr_ff <= hsel && htrans[1] && hready && hwrite;
      wa_ff <= haddr[7:0];
      if (wr_ff && wa_ff == 8'h00)
        ctl_ff <= hwdata[17:0];
      if (wr_ff && wa_ff == 8'h04)
        spd_ff <= hwdata[19:0];
    end
  end
  sequence s_qen;
    (ctl_ff[1] && spd_ff == 20'h00000) [*3];
  endsequence
  sequence s_qdis;
    (!ctl_ff[1]) [*3];
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  property p_hold;
    !rd |=> $stable(hrdata);
  endproperty
  property p_unmap;
    rd && haddr[7:0] > 8'h08 |=> hrdata == 32'h00000000;
  endproperty
  property p_ctl;
    rd && haddr[7:0] == 8'h00 |=> hrdata[17:0] == $past(ctl_ff);
  endproperty
  property p_spd;
    rd && haddr[7:0] == 8'h04 |=> hrdata[19:0] == $past(spd_ff);
  endproperty
  property p_qstat;
    rd && haddr[7:0] == 8'h08 |=> hrdata[8] == $past(quiet_active);
  endproperty
  property p_qon;
    s_qen |-> quiet_active;
  endproperty
  property p_qoff;
    s_qdis |-> !quiet_active;
  endproperty
  property p_pwmoff;
    !quiet_active |=> !pwm_on;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not ready okay");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  a_spd: assert property (p_spd) else $error("speed readback wrong");
  a_qstat: assert property (p_qstat) else $error("status quiet bit wrong");
  a_qon: assert property (p_qon) else $error("quiet mode not entered");
  a_qoff: assert property (p_qoff) else $error("quiet mode while disabled");
  a_pwmoff: assert property (p_pwmoff) else $error("drive outside quiet mode");
endmodule // vpr_asserts
bind vpr_top vpr_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pwm_on(pwm_on),
  .quiet_active(quiet_active));

// [dv/vpr_coil.sv]
/* Coil current and sense comparator model.
   Assumes pwm_on registered on core_clk. */
module vpr_coil (
  input wire logic core_clk,
  input wire logic pwm_on,
  output logic coil_cur_above
);
  timeunit 1ns;
  timeprecision 1ps;
  int cur = 0;
  // Current rises in on phase, decays otherwise
  always @(posedge core_clk)
  begin
    if (pwm_on)
      cur <= cur + 3;
    else if (cur > 0)
      cur <= cur - 1;
  end
  assign coil_cur_above = (cur > 200);
endmodule // vpr_coil

// [dv/tb.sv]
/* Testbench for vpr_top with coil model.
   Assumes AHB-Lite master tasks, 8 ns clock. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic step_pulse = 1'b0;
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic coil_cur_above;
  wire logic pwm_on;
  wire logic quiet_active;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int gap = 0;
  int sc = 0;
  logic [31:0] rv;
  logic [31:0] pt [4] = '{32'h400, 32'h2AB, 32'h200, 32'h19A};
  always #4 core_clk = ~core_clk;
  vpr_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .step_pulse(step_pulse),
    .coil_cur_above(coil_cur_above), .pwm_on(pwm_on), .quiet_active(quiet_active));
  vpr_coil COIL (.core_clk(core_clk), .pwm_on(pwm_on), .coil_cur_above(coil_cur_above));
  // Step pulses every gap cycles
  always @(posedge core_clk)
  begin
    sc <= (sc + 1 >= gap) ? 0 : sc + 1;
    step_pulse <= (gap != 0) && (sc == 0);
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rv & m);
  endtask
  task automatic per(input logic [31:0] e);
    int t;
    @(posedge pwm_on);
    @(posedge pwm_on);
    t = cyc;
    @(posedge pwm_on);
    chk("period", e, 32'(cyc - t));
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    rchk("ctrl", 8'h00, 32'h3FFFF, 32'h1FF41);
    rchk("speed", 8'h04, 32'hFFFFF, 32'h0);
    rchk("status", 8'h08, 32'h1FF, 32'h0);
    rchk("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    bus(1'b1, 8'h00, 32'h00014043);
    repeat (3500) @(posedge core_clk);
    rchk("auto flags", 8'h08, 32'hE00, 32'hA00);
    chk("auto down", 32'h1, {31'h0, rv[7:0] < 8'h40});
    bus(1'b1, 8'h00, 32'h00010041);
    repeat (2) @(posedge core_clk);
    chk("auto off", 32'h0, {31'h0, quiet_active});
    $display("test auto done");
    bus(1'b1, 8'h00, 32'h00014022);
    rchk("entry", 8'h08, 32'h1FF, 32'h140);
    gap = 16;
    repeat (600) @(posedge core_clk);
    rchk("ff amp", 8'h08, 32'hFF, 32'h60);
    bus(1'b1, 8'h00, 32'h0001F0F2);
    repeat (600) @(posedge core_clk);
    rchk("sat amp", 8'h08, 32'hFF, 32'hFF);
    gap = 0;
    repeat (600) @(posedge core_clk);
    rchk("idle amp", 8'h08, 32'hFF, 32'hF0);
    $display("test feed forward done");
    for (int r = 0; r < 4; r++)
    begin
      bus(1'b1, 8'h00, 32'h00018002 | {28'h0, 2'(r), 2'h0});
      per(pt[r]);
    end
    $display("test rates done");
    gap = 100;
    bus(1'b1, 8'h04, 32'h000000C8);
    bus(1'b1, 8'h00, 32'h00015043);
    repeat (1000) @(posedge core_clk);
    chk("fast quiet", 32'h0, {31'h0, quiet_active});
    gap = 400;
    repeat (3000) @(posedge core_clk);
    chk("slow quiet", 32'h1, {31'h0, quiet_active});
    rchk("reentry", 8'h08, 32'h9FF, 32'h150);
    $display("test threshold done");
    summarize();
  end
endmodule // tb
